// ### codec_ctrl_pkg.sv
// shared constants and carrier types for the codec control register set
package codec_ctrl_pkg;

  // register indices carried in the low nibble of the instruction byte
  localparam logic [3:0] REG_SLOT_CTRL   = 4'h1;
  localparam logic [3:0] REG_RX_ACCESS   = 4'h2;
  localparam logic [3:0] REG_TX_INJECT   = 4'h3;
  localparam logic [3:0] REG_ROUTING     = 4'h4;
  localparam logic [3:0] REG_TX_GAIN     = 4'h5;
  localparam logic [3:0] REG_RX_GAIN     = 4'h6;
  localparam logic [3:0] REG_TONE_MODE   = 4'h7;
  localparam logic [3:0] REG_TONE_A_FREQ = 4'h8;
  localparam logic [3:0] REG_TONE_B_FREQ = 4'h9;
  localparam logic [3:0] REG_BOOST       = 4'ha;

  // instruction byte layout
  localparam int INST_READ_BIT = 7;
  localparam int INST_ADDR_LSB = 0;
  localparam int INST_ADDR_W   = 4;
  localparam logic [3:0] INST_BYTE_LAST = 4'h7;
  localparam logic [3:0] INST_WORD_LAST = 4'hf;

  // slot control fields
  localparam int SC_HANDS_FREE = 7;
  localparam int SC_ANTI_LARSEN = 6;
  localparam int SC_LATCH      = 5;
  localparam int SC_RX_FROM_REG = 4;
  localparam int SC_TX_FROM_REG = 3;
  localparam int SC_VOICE_ON   = 2;
  localparam int SC_SLOT_HI    = 1;
  localparam int SC_SLOT_LO    = 0;

  // tone mode fields
  localparam int TM_PICK_A  = 3;
  localparam int TM_PICK_B  = 2;
  localparam int TM_SHAPE   = 1;
  localparam int TM_TO_TX   = 0;

  // boost register fields
  localparam int BR_BOOST   = 7;
  localparam int BR_CLIP_ON = 6;
  localparam int BR_THR_LSB = 4;
  localparam int BR_REL_LSB = 2;
  localparam int BR_DOUBLE  = 1;
  localparam int BR_HALF    = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // pcm framing: eight bits per slot, four slots at most
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
  localparam logic [5:0] FRAME_BIT_MAX = 6'h3f;

  // tone sample rate; phase step per sample is freq/rate*2^16
  localparam int CLK_HZ       = 20_000_000;
  localparam int TONE_RATE_HZ = 8_000;
  localparam int TICK_CYCLES  = CLK_HZ / TONE_RATE_HZ;
  // register*7.8125 Hz /8000 Hz *65536 = register*64
  localparam int STEP_SHIFT_STD  = 6;
  localparam int STEP_SHIFT_DBL  = 7;
  localparam int STEP_SHIFT_HALF = 5;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_INST = 2'b01,
    SER_DATA = 2'b11
  } ser_state_t;

  typedef struct packed {
    logic mic_source_choice;
    logic tx_input_on;
    logic sidetone_on;
    logic aux_to_speaker;
    logic tone_to_speaker;
    logic tone_to_earpiece;
    logic rx_speech_to_speaker;
    logic rx_speech_to_earpiece;
  } routing_t;

  typedef struct packed {
    logic [3:0] tx_gain;
    logic [3:0] sidetone_att;
    logic [3:0] earpiece_att;
    logic [3:0] speaker_att;
    logic [3:0] tone_att;
    logic       speaker_boost_bit;
    logic       anticlip_on;
    logic [1:0] clip_threshold_field;
    logic [1:0] release_time_field;
  } gain_t;

endpackage : codec_ctrl_pkg

// ### codec_control_register_set.sv
// control register set, serial control port, pcm slot access and tone generator
// What this block does
// - latch bit zero floats the latch pin, one drives it low.
// - receive-from-register bit feeds written byte to decoder; reads return received byte.
// - transmit-from-register bit sends the inject byte instead of encoder output.
// - voice gate low stops decoding and floats transmit slots.
// - in GCI mode both slot bits pick one of four channels.
// - in separate-control PCM mode the upper slot bit is ignored.
// - routing bit 7 picks microphone, bit 6 passes or mutes it.
// - bit 5 switches sidetone, forced off while transmit input is muted.
// - routing bits 3 and 2 send tone to speaker and/or earpiece.
// - routing bits 1 and 0 send received speech to speaker and/or earpiece.
// - gain register bits 7..4 set transmit gain 0 to 15 dB.
// - receive gain upper nibble sets earpiece gain 0 to -15 dB.
// - receive gain lower nibble sets speaker gain 0 to -30 dB, 2 dB steps.
// - tone bits 3,2 enable generators; first alone square, second alone sine unless tone bit 1 is set.
// - frequency changes keep phase continuous and apply within one sample.
// - tone bit 1 selects sine or square for the second generator only.
// - tone bit 0 routes tone into transmit data path.
// - standard range frequency is register value over 0.128 Hz.
// - double range frequency is register value over 0.064 Hz.
// - speaker boost bit selects 27 dB or 9 dB maximum gain.
// - anticlip bit enables anticlipping; bits 5,4 pick its threshold.
// - boost register bits 3,2 pick anticlip release time.
`timescale 1ns/1ps
`default_nettype none

module codec_control_register_set
  import codec_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial control port
  input  wire logic        ctl_clk,
  input  wire logic        ctl_sel_n,
  input  wire logic        ctl_din,
  output logic             ctl_dout,
  output logic             ctl_dout_oe,
  // pcm bus
  input  wire logic        pcm_bit_clk,
  input  wire logic        pcm_frame_sync,
  input  wire logic        pcm_receive_input,
  input  wire logic        gci_mode,
  output logic             pcm_transmit_output,
  output logic             pcm_transmit_oe,
  // encoder byte and decoder stream
  input  wire logic [7:0]  enc_byte,
  output logic [7:0]       dec_data,
  output logic             dec_valid,
  input  wire logic        dec_ready,
  // latch pin
  output logic             latch_out_pin,
  output logic             latch_out_oe,
  // analog controls
  output routing_t         routing,
  output gain_t            gains,
  output logic             hands_free_on,
  output logic             anti_larsen_on,
  output logic             tone_onto_tx_data,
  output logic signed [7:0] tone_sample
);

  // reset release through two flops
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_l_n = rst_s2_q;

  // pin synchronisers: first stage read only by second
  localparam int NSYNC = 7;
  // idle pin levels, so no false clock edge or select follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h03;
  logic [NSYNC-1:0] pin_raw, sync1_q, sync2_q, sync3_q;
  assign pin_raw = {gci_mode, pcm_receive_input, pcm_frame_sync, pcm_bit_clk,
                    ctl_din, ctl_sel_n, ctl_clk};
  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
      sync3_q <= SYNC_IDLE;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  wire logic cclk_rise = sync2_q[0] & ~sync3_q[0];
  wire logic cclk_fall = ~sync2_q[0] & sync3_q[0];
  wire logic sel_n     = sync2_q[1];
  wire logic sdin      = sync2_q[2];
  wire logic bclk_rise = sync2_q[3] & ~sync3_q[3];
  wire logic fs_rise   = sync2_q[4] & ~sync3_q[4];
  wire logic dr_bit    = sync2_q[5];
  wire logic gci_s     = sync2_q[6];

  // register storage
  logic [7:0] slot_ctrl_q, rx_inject_q, tx_inject_q, routing_q, tx_gain_q;
  logic [7:0] rx_gain_q, tone_mode_q, freq_a_q, freq_b_q, boost_q;
  logic [7:0] rx_byte_q;

  function automatic logic [7:0] reg_read(input logic [3:0] a);
    unique case (a)
      REG_SLOT_CTRL:   reg_read = slot_ctrl_q;
      // reads show byte received this frame
      REG_RX_ACCESS:   reg_read = rx_byte_q;
      REG_ROUTING:     reg_read = routing_q;
      REG_TX_GAIN:     reg_read = tx_gain_q;
      REG_RX_GAIN:     reg_read = rx_gain_q;
      REG_TONE_MODE:   reg_read = tone_mode_q;
      REG_TONE_A_FREQ: reg_read = freq_a_q;
      REG_TONE_B_FREQ: reg_read = freq_b_q;
      REG_BOOST:       reg_read = boost_q;
      default:         reg_read = READ_ZERO;
    endcase
  endfunction : reg_read

  // serial control port: 8-bit instruction then 8-bit data, msb first
  ser_state_t ser_q;
  logic [3:0] ser_cnt_q;
  logic [7:0] inst_q, shift_q, rd_shift_q;
  logic       wr_stb_d;
  logic [3:0] wr_addr_d;
  logic [7:0] wr_data_d;
  // address comes from the byte being completed, not the shifter one bit behind
  logic [7:0] rd_pick;
  assign rd_pick = reg_read(wr_data_d[INST_ADDR_LSB +: INST_ADDR_W]);

  always_comb begin
    wr_stb_d  = 1'b0;
    wr_addr_d = inst_q[INST_ADDR_LSB +: INST_ADDR_W];
    wr_data_d = {shift_q[6:0], sdin};
    if (!sel_n && cclk_rise && ser_q == SER_DATA && ser_cnt_q == INST_WORD_LAST
        && !inst_q[INST_READ_BIT]) begin
      wr_stb_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      ser_q      <= SER_IDLE;
      ser_cnt_q  <= '0;
      inst_q     <= '0;
      shift_q    <= '0;
      rd_shift_q <= '0;
      ctl_dout   <= 1'b0;
      ctl_dout_oe <= 1'b0;
    end else if (sel_n) begin
      ser_q       <= SER_IDLE;
      ser_cnt_q   <= '0;
      ctl_dout_oe <= 1'b0;
    end else begin
      if (ser_q == SER_IDLE) begin
        ser_q <= SER_INST;
      end
      if (cclk_rise) begin
        shift_q   <= {shift_q[6:0], sdin};
        ser_cnt_q <= ser_cnt_q + 4'h1;
        if (ser_cnt_q == INST_BYTE_LAST) begin
          inst_q <= {shift_q[6:0], sdin};
          ser_q  <= SER_DATA;
          if (shift_q[INST_READ_BIT-1]) begin
            rd_shift_q  <= rd_pick;
            ctl_dout    <= rd_pick[7];
            ctl_dout_oe <= 1'b1;
          end
        end
        if (ser_cnt_q == INST_WORD_LAST) begin
          ctl_dout_oe <= 1'b0;
        end
      end else if (cclk_fall && ser_q == SER_DATA && ctl_dout_oe) begin
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        ctl_dout   <= rd_shift_q[6];
      end
    end
  end

  // registers hold until rewritten or reset
  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      slot_ctrl_q <= REG_RESET;
      rx_inject_q <= REG_RESET;
      tx_inject_q <= REG_RESET;
      routing_q   <= REG_RESET;
      tx_gain_q   <= REG_RESET;
      rx_gain_q   <= REG_RESET;
      tone_mode_q <= REG_RESET;
      freq_a_q    <= REG_RESET;
      freq_b_q    <= REG_RESET;
      boost_q     <= REG_RESET;
    end else if (wr_stb_d) begin
      unique case (wr_addr_d)
        REG_SLOT_CTRL:   slot_ctrl_q <= wr_data_d;
        REG_RX_ACCESS:   rx_inject_q <= wr_data_d;
        REG_TX_INJECT:   tx_inject_q <= wr_data_d;
        REG_ROUTING:     routing_q   <= wr_data_d;
        REG_TX_GAIN:     tx_gain_q   <= wr_data_d;
        REG_RX_GAIN:     rx_gain_q   <= wr_data_d;
        REG_TONE_MODE:   tone_mode_q <= wr_data_d;
        REG_TONE_A_FREQ: freq_a_q    <= wr_data_d;
        REG_TONE_B_FREQ: freq_b_q    <= wr_data_d;
        REG_BOOST:       boost_q     <= wr_data_d;
        default:         ;
      endcase
    end
  end

  // pcm slot engine
  logic [5:0] bit_cnt_q;
  logic       in_frame_q;
  logic [7:0] tx_shift_q, rx_shift_q;
  logic [1:0] slot_sel;
  logic       in_window, last_bit, buf_in_ready;
  wire logic  voice_on = slot_ctrl_q[SC_VOICE_ON];

  // gci uses both bits; pcm mode ignores the upper bit
  assign slot_sel  = gci_s ? slot_ctrl_q[SC_SLOT_HI:SC_SLOT_LO]
                           : {1'b0, slot_ctrl_q[SC_SLOT_LO]};
  assign in_window = in_frame_q && (bit_cnt_q[4:3] == slot_sel) && !bit_cnt_q[5];
  assign last_bit  = in_window && (bit_cnt_q[2:0] == SLOT_LAST_BIT);

  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      bit_cnt_q           <= '0;
      in_frame_q          <= 1'b0;
      tx_shift_q          <= '0;
      rx_shift_q          <= '0;
      rx_byte_q           <= '0;
      pcm_transmit_output <= 1'b0;
      pcm_transmit_oe     <= 1'b0;
    end else if (fs_rise) begin
      bit_cnt_q  <= '0;
      in_frame_q <= 1'b1;
      tx_shift_q <= slot_ctrl_q[SC_TX_FROM_REG] ? tx_inject_q : enc_byte;
    end else if (bclk_rise && in_frame_q) begin
      bit_cnt_q <= bit_cnt_q + 6'h1;
      if (bit_cnt_q == FRAME_BIT_MAX) begin
        in_frame_q <= 1'b0;
      end
      // slots float while voice gate is low
      pcm_transmit_oe <= in_window && voice_on;
      if (in_window) begin
        pcm_transmit_output <= tx_shift_q[7];
        tx_shift_q          <= {tx_shift_q[6:0], 1'b0};
        rx_shift_q          <= {rx_shift_q[6:0], dr_bit};
      end
      if (last_bit) begin
        rx_byte_q <= {rx_shift_q[6:0], dr_bit};
      end
    end
  end

  // decoder feed; a full buffer blocks the push and that frame's byte is skipped
  logic       push;
  logic [7:0] push_data;
  always_comb begin
    // nothing goes to the decoder while the voice gate is low
    push = bclk_rise && last_bit && voice_on && buf_in_ready;
    // written byte replaces the line each frame
    push_data = slot_ctrl_q[SC_RX_FROM_REG] ? rx_inject_q : {rx_shift_q[6:0], dr_bit};
  end

  // two-entry buffer: output stage plus skid stage
  logic       spare_valid_q;
  logic [7:0] spare_q;
  assign buf_in_ready = !spare_valid_q;
  wire logic pop = dec_valid && dec_ready;

  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      dec_valid     <= 1'b0;
      dec_data      <= '0;
      spare_valid_q <= 1'b0;
      spare_q       <= '0;
    end else begin
      if (!dec_valid || pop) begin
        if (spare_valid_q) begin
          dec_data      <= spare_q;
          dec_valid     <= 1'b1;
          spare_valid_q <= push;
          spare_q       <= push_data;
        end else begin
          dec_valid <= push;
          dec_data  <= push ? push_data : dec_data;
        end
      end else if (push) begin
        spare_valid_q <= 1'b1;
        spare_q       <= push_data;
      end
    end
  end

  // tone generator, two phase accumulators at the sample rate
  logic [11:0] tick_cnt_q;
  wire logic   tick = (tick_cnt_q == 12'(TICK_CYCLES - 1));
  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 12'h1;
    end
  end

  function automatic logic [15:0] phase_step(input logic [7:0] f, input logic dbl,
                                            input logic half);
    if (dbl) begin
      phase_step = {1'b0, f, 7'h00};
    // half range, software keeps the two bits exclusive
    end else if (half) begin
      phase_step = {3'b000, f, 5'h00};
    end else begin
      phase_step = {2'b00, f, 6'h00};
    end
  endfunction : phase_step

  function automatic logic signed [7:0] sine_of(input logic [15:0] ph);
    logic [3:0] idx;
    logic [6:0] mag;
    idx = ph[14] ? ~ph[13:10] : ph[13:10];
    unique case (idx)
      4'h0: mag = 7'd6;    4'h1: mag = 7'd19;   4'h2: mag = 7'd31;   4'h3: mag = 7'd43;
      4'h4: mag = 7'd54;   4'h5: mag = 7'd65;   4'h6: mag = 7'd76;   4'h7: mag = 7'd85;
      4'h8: mag = 7'd94;   4'h9: mag = 7'd102;  4'ha: mag = 7'd109;  4'hb: mag = 7'd115;
      4'hc: mag = 7'd120;  4'hd: mag = 7'd123;  4'he: mag = 7'd126;  4'hf: mag = 7'd127;
    endcase
    sine_of = ph[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sine_of

  function automatic logic signed [7:0] square_of(input logic [15:0] ph);
    square_of = ph[15] ? -8'sd127 : 8'sd127;
  endfunction : square_of

  logic [15:0] phase_q [2];
  logic [7:0]  freq_reg [2];
  assign freq_reg[0] = freq_a_q;
  assign freq_reg[1] = freq_b_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_tone
      // accumulator never reset on a new step, so phase stays continuous
      always_ff @(posedge mclk or negedge rst_l_n) begin
        if (!rst_l_n) begin
          phase_q[g] <= '0;
        end else if (tick) begin
          phase_q[g] <= phase_q[g] + phase_step(freq_reg[g], boost_q[BR_DOUBLE],
                                                boost_q[BR_HALF]);
        end
      end
    end
  endgenerate

  logic signed [7:0] wave_a, wave_b, mix;
  always_comb begin
    // shape bit picks square over sine for the second generator; the first is always square
    wave_a = square_of(phase_q[0]);
    wave_b = tone_mode_q[TM_SHAPE] ? square_of(phase_q[1]) : sine_of(phase_q[1]);
    // generator enables, summed when both picked
    unique case ({tone_mode_q[TM_PICK_A], tone_mode_q[TM_PICK_B]})
      2'b10:   mix = wave_a;
      2'b01:   mix = wave_b;
      2'b11:   mix = (wave_a >>> 1) + (wave_b >>> 1);
      default: mix = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      tone_sample <= '0;
    end else if (tick) begin
      tone_sample <= mix;
    end
  end

  // analog control outputs, registered so each comes from a flop
  always_ff @(posedge mclk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      routing           <= '0;
      gains             <= '0;
      hands_free_on     <= 1'b0;
      anti_larsen_on    <= 1'b0;
      tone_onto_tx_data <= 1'b0;
      latch_out_pin     <= 1'b0;
      latch_out_oe      <= 1'b0;
    end else begin
      routing.mic_source_choice     <= routing_q[7];
      routing.tx_input_on           <= routing_q[6];
      // sidetone needs the transmit input on
      routing.sidetone_on           <= routing_q[5] & routing_q[6];
      routing.aux_to_speaker        <= routing_q[4];
      routing.tone_to_speaker       <= routing_q[3];
      routing.tone_to_earpiece      <= routing_q[2];
      routing.rx_speech_to_speaker  <= routing_q[1];
      routing.rx_speech_to_earpiece <= routing_q[0];
      gains.tx_gain                 <= tx_gain_q[7:4];
      gains.sidetone_att            <= tx_gain_q[3:0];
      gains.earpiece_att            <= rx_gain_q[7:4];
      // speaker attenuation, 2 dB per code
      gains.speaker_att             <= rx_gain_q[3:0];
      gains.tone_att                <= tone_mode_q[7:4];
      gains.speaker_boost_bit       <= boost_q[BR_BOOST];
      gains.anticlip_on             <= boost_q[BR_CLIP_ON];
      gains.clip_threshold_field    <= boost_q[BR_THR_LSB +: 2];
      gains.release_time_field      <= boost_q[BR_REL_LSB +: 2];
      hands_free_on                 <= slot_ctrl_q[SC_HANDS_FREE];
      anti_larsen_on                <= slot_ctrl_q[SC_ANTI_LARSEN];
      tone_onto_tx_data             <= tone_mode_q[TM_TO_TX];
      // open-drain latch, drives low only when bit is one
      latch_out_pin                 <= 1'b0;
      latch_out_oe                  <= slot_ctrl_q[SC_LATCH];
    end
  end

endmodule : codec_control_register_set

`default_nettype wire

// ### codec_ctrl_asserts.sv
// concurrent checks on the ports of the codec control register set
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_asserts
  import codec_ctrl_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // serial port
  input wire logic              ctl_sel_n,
  input wire logic              ctl_dout_oe,
  // decoder stream
  input wire logic [7:0]        dec_data,
  input wire logic              dec_valid,
  input wire logic              dec_ready,
  // controls
  input wire logic              latch_out_pin,
  input wire logic              latch_out_oe,
  input wire routing_t          routing,
  input wire gain_t             gains,
  input wire logic signed [7:0] tone_sample
);
  int unsigned tcnt_q;
  logic        armed_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a sample may repeat its value, so only the phase of a change is judged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q  <= 0;
      armed_q <= 1'b0;
    end else if ($changed(tone_sample)) begin
      tcnt_q  <= 0;
      armed_q <= 1'b1;
    end else begin
      tcnt_q <= tcnt_q + 1;
    end
  end
  property p_latch_low; latch_out_pin == 1'b0; endproperty
  a_latch_low: assert property (p_latch_low) else $error("latch pin driven high");
  property p_latch_src; $changed(latch_out_oe) |-> !$past(ctl_sel_n, 3); endproperty
  a_latch_src: assert property (p_latch_src) else $error("latch moved without write");
  property p_route_src; $changed(routing) |-> !$past(ctl_sel_n, 3); endproperty
  a_route_src: assert property (p_route_src) else $error("routing moved without write");
  property p_gain_src; $changed(gains) |-> !$past(ctl_sel_n, 3); endproperty
  a_gain_src: assert property (p_gain_src) else $error("gains moved without write");
  property p_side_off; routing.sidetone_on |-> routing.tx_input_on; endproperty
  a_side_off: assert property (p_side_off) else $error("sidetone on while muted");
  property p_dec_hold; dec_valid && !dec_ready |=> dec_valid && $stable(dec_data); endproperty
  a_dec_hold: assert property (p_dec_hold) else $error("decoder word lost in stall");
  property p_oe_start; $rose(ctl_dout_oe) |-> !ctl_sel_n; endproperty
  a_oe_start: assert property (p_oe_start) else $error("read drive while idle");
  property p_oe_end; $rose(ctl_sel_n) |-> ##[1:6] !ctl_dout_oe; endproperty
  a_oe_end: assert property (p_oe_end) else $error("read drive after deselect");
  property p_tick; armed_q && $changed(tone_sample) |-> tcnt_q % TICK_CYCLES == TICK_CYCLES - 1;
  endproperty
  a_tick: assert property (p_tick) else $error("tone sample off its tick");
endmodule : codec_ctrl_asserts
bind codec_control_register_set codec_ctrl_asserts chk_i (.mclk, .rst_n, .ctl_sel_n,
  .ctl_dout_oe, .dec_data, .dec_valid, .dec_ready, .latch_out_pin, .latch_out_oe,
  .routing, .gains, .tone_sample);
`default_nettype wire

// ### ctl_host.sv
// microcontroller model on the serial control port and the pcm bus
`timescale 1ns/1ps
`default_nettype none
module ctl_host (
  // clock
  input wire logic  mclk,
  // serial control port
  output logic      ctl_clk,
  output logic      ctl_sel_n,
  output logic      ctl_din,
  input wire logic  ctl_dout,
  // pcm bus
  output logic      pcm_bit_clk,
  output logic      pcm_frame_sync,
  output logic      pcm_receive_input,
  input wire logic  pcm_transmit_output,
  input wire logic  pcm_transmit_oe
);
  initial begin
    ctl_clk = 1'b1;
    ctl_sel_n = 1'b1;
    ctl_din = 1'b0;
    pcm_bit_clk = 1'b0;
    pcm_frame_sync = 1'b0;
    pcm_receive_input = 1'b0;
  end
  // nb below 16 drops select early, which aborts the transfer
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input int nb,
                      output logic [7:0] rd);
    logic [15:0] w;
    w = {ins, dat};
    rd = 8'h00;
    @(negedge mclk);
    ctl_sel_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (5) @(negedge mclk);
      if (i >= 8) rd = {rd[6:0], ctl_dout};
      ctl_clk <= 1'b0;
      ctl_din <= w[15-i];
      repeat (5) @(negedge mclk);
      ctl_clk <= 1'b1;
    end
    repeat (5) @(negedge mclk);
    repeat (3) @(negedge mclk);
    ctl_sel_n <= 1'b1;
    // released data line must not keep its last level
    ctl_din <= ~ctl_din;
    repeat (6) @(negedge mclk);
  endtask : xfer
  // every slot carries rb; slot reports the first slot seen driven
  task automatic frame(input logic [7:0] rb, output logic [7:0] txb, output int slot);
    txb = 8'h00;
    slot = -1;
    @(negedge mclk);
    pcm_frame_sync <= 1'b1;
    for (int b = 0; b < 64; b++) begin
      pcm_receive_input <= rb[3'd7-b[2:0]];
      repeat (4) @(negedge mclk);
      pcm_bit_clk <= 1'b1;
      repeat (6) @(negedge mclk);
      pcm_bit_clk <= 1'b0;
      pcm_frame_sync <= 1'b0;
      if (pcm_transmit_oe === 1'b1) begin
        if (slot < 0) slot = b / 8;
        txb = {txb[6:0], pcm_transmit_output};
      end
    end
    pcm_receive_input <= ~pcm_receive_input;
  endtask : frame
endmodule : ctl_host
`default_nettype wire

// ### codec_control_register_set_tb_top.sv
// self-checking bench for the codec control register set
`timescale 1ns/1ps
`default_nettype none
module codec_control_register_set_tb_top
  import codec_ctrl_pkg::*;
;
  logic mclk, rst_n, gci_mode, dec_ready, dec_valid;
  logic ctl_clk, ctl_sel_n, ctl_din, ctl_dout, ctl_dout_oe;
  logic pcm_bit_clk, pcm_frame_sync, pcm_receive_input, pcm_transmit_output, pcm_transmit_oe;
  logic latch_out_pin, latch_out_oe, hands_free_on, anti_larsen_on, tone_onto_tx_data;
  logic [7:0] enc_byte, dec_data, rd, txb;
  logic signed [7:0] tone_sample;
  routing_t routing;
  gain_t gains;
  int n_errors, cmp_count, slot;
  logic [7:0] q[$];
  // row: index, written, read back, seen at the ports
  logic [31:0] rows [13] = '{32'h01e0_e0e0, 32'h04a5_a585, 32'h047f_7f7f, 32'h05f3_f3f3,
    32'h060f_0f0f, 32'h06f0_f0f0, 32'h0751_5151, 32'h0afe_fefc, 32'h0880_8000,
    32'h092a_2a00, 32'h035a_0000, 32'h0b33_0000, 32'h0100_0000};
  codec_control_register_set uut (.mclk, .rst_n, .ctl_clk, .ctl_sel_n, .ctl_din, .ctl_dout,
    .ctl_dout_oe, .pcm_bit_clk, .pcm_frame_sync, .pcm_receive_input, .gci_mode,
    .pcm_transmit_output, .pcm_transmit_oe, .enc_byte, .dec_data, .dec_valid, .dec_ready,
    .latch_out_pin, .latch_out_oe, .routing, .gains, .hands_free_on, .anti_larsen_on,
    .tone_onto_tx_data, .tone_sample);
  ctl_host host (.mclk, .ctl_clk, .ctl_sel_n, .ctl_din, .ctl_dout, .pcm_bit_clk,
    .pcm_frame_sync, .pcm_receive_input, .pcm_transmit_output, .pcm_transmit_oe);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] seen(input logic [7:0] idx);
    case (idx)
      8'h01: seen = {hands_free_on, anti_larsen_on, latch_out_oe, 5'h00};
      8'h04: seen = routing;
      8'h05: seen = {gains.tx_gain, gains.sidetone_att};
      8'h06: seen = {gains.earpiece_att, gains.speaker_att};
      8'h07: seen = {gains.tone_att, 3'h0, tone_onto_tx_data};
      8'h0a: seen = {gains.speaker_boost_bit, gains.anticlip_on, gains.clip_threshold_field,
                     gains.release_time_field, 2'h0};
      default: seen = 8'h00;
    endcase
  endfunction : seen
  // the receiver stalls, then takes every held word
  task automatic drain();
    q.delete();
    dec_ready <= 1'b1;
    repeat (8) begin
      if (dec_valid === 1'b1) q.push_back(dec_data);
      @(negedge mclk);
    end
    dec_ready <= 1'b0;
  endtask : drain
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    gci_mode = 1'b0;
    dec_ready = 1'b0;
    enc_byte = 8'ha7;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    for (int r = 1; r <= 10; r++) begin
      host.xfer(8'h80 | 8'(r), 8'h00, 16, rd);
      chk("reset value", 8'h00, rd);
    end
    // the boost row sets double range only, never both range bits
    foreach (rows[i]) begin
      host.xfer(rows[i][31:24], rows[i][23:16], 16, rd);
      repeat (4) @(negedge mclk);
      chk("port field", rows[i][7:0], seen(rows[i][31:24]));
      host.xfer(8'h80 | rows[i][31:24], 8'h00, 16, rd);
      chk("read back", rows[i][15:8], rd);
    end
    host.xfer(8'h05, 8'h11, 12, rd);
    host.xfer(8'h85, 8'h00, 16, rd);
    chk("aborted write", 8'hf3, rd);
    host.xfer(8'h03, 8'hc3, 16, rd);
    host.xfer(8'h02, 8'h96, 16, rd);
    host.xfer(8'h01, 8'h1c, 16, rd);
    host.frame(8'h3c, txb, slot);
    chk("inject byte", 8'hc3, txb);
    drain();
    chk("decoded from register", 8'h96, q.size() == 1 ? q[0] : 8'hxx);
    host.xfer(8'h82, 8'h00, 16, rd);
    chk("received byte", 8'h3c, rd);
    host.xfer(8'h01, 8'h18, 16, rd);
    host.frame(8'h3c, txb, slot);
    chk("gated slot", 8'hff, 8'(slot));
    chk("gated push", 8'h00, {7'h00, dec_valid});
    host.xfer(8'h01, 8'h07, 16, rd);
    gci_mode = 1'b1;
    host.frame(8'h5a, txb, slot);
    chk("gci slot", 8'h03, 8'(slot));
    chk("encoder byte", 8'ha7, txb);
    gci_mode = 1'b0;
    host.frame(8'h66, txb, slot);
    chk("pcm slot", 8'h01, 8'(slot));
    host.frame(8'h99, txb, slot);
    drain();
    chk("held words", 8'h02, 8'(q.size()));
    chk("first word", 8'h5a, q.size() > 1 ? q[0] : 8'hxx);
    chk("second word", 8'h66, q.size() > 1 ? q[1] : 8'hxx);
    host.xfer(8'h08, 8'h80, 16, rd);
    host.xfer(8'h07, 8'h08, 16, rd);
    rd = tone_sample;
    for (int k = 0; k < 6000 && tone_sample === rd; k++) @(negedge mclk);
    chk("tone running", 8'h01, {7'h00, tone_sample !== rd});
    conclude();
  end
endmodule : codec_control_register_set_tb_top
`default_nettype wire
